// >>> logic/pcwc_top.sv
// Purpose: prefetch, flash wait-state and cache attribute control
// Assumes: single clock, flash data valid ws+1 cycles after flash_rd
// Notes:   one-entry prefetch buffer, word addresses
//
// What this block does
// - mode field picks which accesses prefetch
// - wait field 000 zero, 001 one wait
// - 010 gives two, 100 four waits
// - 011 reserved and refused; 111 seven waits
// - wait bands assume flash error correction on
// - cache attribute encodes write policy, non-coherent
// - attribute sits in coprocessor register sixteen
// - one attribute drives both instruction and data caches
// - boot bit picks exception isa flag, field
// - compressed mode decodes short and long opcodes on demand fetches; prefetch hits return fetch_is32 high
`timescale 1ns/10ps
module pcwc_top (
    input  wire logic                    clk,
    input  wire logic                    ce,
    input  wire logic                    reset,
    input  wire logic [pcwc_pkg::RAW-1:0] reg_addr,
    input  wire logic [31:0]             reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic [31:0]                  reg_rdata,
    input  wire logic                    boot_instruction_set_select,
    input  wire logic                    fetch_req,
    input  wire pcwc_pkg::pcwc_acc_e     fetch_kind,
    input  wire logic [pcwc_pkg::AW-1:0] fetch_addr,
    output logic                         fetch_ready,
    output logic                         fetch_valid,
    output logic [pcwc_pkg::DW-1:0]      fetch_rdata,
    output logic                         fetch_is32,
    output logic                         flash_rd,
    output logic [pcwc_pkg::AW-1:0]      flash_addr,
    input  wire logic [pcwc_pkg::DW-1:0] flash_rdata,
    output logic                         flash_ecc_en,
    output logic                         icache_cacheable,
    output logic                         icache_wback,
    output logic                         icache_walloc,
    output logic                         dcache_cacheable,
    output logic                         dcache_wback,
    output logic                         dcache_walloc,
    output logic                         exception_isa_flag,
    output logic [1:0]                   isa_mode
);
    import pcwc_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DEMAND,
        ST_PREF
    } pcwc_state_e;

    pcwc_core_if core ();

    // ***********************************************************
    // register state
    // ***********************************************************
    logic [1:0] prefetch_mode_select;
    logic [2:0] flash_wait_state_count;
    logic       ecc_en;
    logic [2:0] fixed_segment_cache_policy;
    logic       rsvd_wr;
    logic [1:0] next_pf_mode;
    logic [2:0] next_ws;
    logic       next_ecc;
    logic [2:0] next_k0;
    logic       next_rsvd;
    logic [31:0] next_rdata;
    logic       ctl_wr;

    // ***********************************************************
    // boot configuration
    // ***********************************************************
    logic       boot_s1;
    logic       boot_s2;
    logic [1:0] cfg_cnt;
    logic       boot_sel;
    logic [1:0] next_cfg_cnt;
    logic       next_boot_sel;

    // ***********************************************************
    // fetch state
    // ***********************************************************
    pcwc_state_e state;
    pcwc_state_e next_state;
    pcwc_acc_e   kind;
    pcwc_acc_e   next_kind;
    logic        pf_valid;
    logic [AW-1:0] pf_addr;
    logic [DW-1:0] pf_data;
    logic        next_pf_valid;
    logic [AW-1:0] next_pf_addr;
    logic [DW-1:0] next_pf_data;
    logic        next_fetch_valid;
    logic [DW-1:0] next_fetch_rdata;
    logic        next_fetch_is32;
    logic        next_flash_rd;
    logic [AW-1:0] next_flash_addr;
    logic        accept;
    logic        pf_hit;
    logic        pf_allow;

    // ***********************************************************
    // submodules
    // ***********************************************************
    pcwc_wait_timer u_timer (
        .clk   (clk),
        .ce    (ce),
        .reset (reset),
        .bus   (core.timer)
    );

    pcwc_isa_decode u_isa (
        .bus (core.isa)
    );

    assign core.ws       = flash_wait_state_count;
    assign core.boot_sel = boot_sel;
    assign core.hword    = flash_rdata[15:0];

    // ***********************************************************
    // register port
    // ***********************************************************
    assign ctl_wr = reg_wr && (reg_addr == REG_PREFETCH_CONTROL_REG);

    always_comb begin
        next_pf_mode = prefetch_mode_select;
        next_ws      = flash_wait_state_count;
        next_ecc     = ecc_en;
        next_k0      = fixed_segment_cache_policy;
        next_rsvd    = rsvd_wr;
        next_rdata   = 32'h00000000;
        if (ctl_wr) begin
            next_pf_mode = reg_wdata[PF_LSB+:2];
            next_ecc     = reg_wdata[ECC_BIT];
            if (reg_wdata[WS_LSB+:3] == WS_RSVD) begin
                next_rsvd = 1'b1;
            end else begin
                next_ws = reg_wdata[WS_LSB+:3];
            end
        end
        if (reg_wr && (reg_addr == REG_CP0_16)) begin
            next_k0 = reg_wdata[K0_LSB+:3];
        end
        if (reg_wr && (reg_addr == REG_STATUS) && reg_wdata[ST_RSVD_BIT]) begin
            next_rsvd = 1'b0;
        end
        if (reg_rd) begin
            unique case (reg_addr)
                REG_PREFETCH_CONTROL_REG: begin
                    next_rdata[PF_LSB+:2] = prefetch_mode_select;
                    next_rdata[WS_LSB+:3] = flash_wait_state_count;
                    next_rdata[ECC_BIT]   = ecc_en;
                end
                REG_CP0_16: begin
                    next_rdata[K0_LSB+:3] = fixed_segment_cache_policy;
                end
                REG_CFG3: begin
                    next_rdata[EXC_ISA_BIT] = exception_isa_flag;
                    next_rdata[ISA_LSB+:2]  = isa_mode;
                end
                REG_STATUS: begin
                    next_rdata[ST_RSVD_BIT] = rsvd_wr;
                    next_rdata[ST_BUSY_BIT] = (state != ST_IDLE);
                    next_rdata[ST_PFV_BIT]  = pf_valid;
                    next_rdata[ST_BOOT_BIT] = boot_sel;
                end
                default: begin
                    next_rdata = 32'h00000000;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prefetch_mode_select       <= PF_RST;
            flash_wait_state_count     <= WS_RST;
            ecc_en                     <= ECC_RST;
            fixed_segment_cache_policy <= K0_RST;
            rsvd_wr                    <= 1'b0;
            reg_rdata                  <= 32'h00000000;
        end else if (ce) begin
            prefetch_mode_select       <= next_pf_mode;
            flash_wait_state_count     <= next_ws;
            ecc_en                     <= next_ecc;
            fixed_segment_cache_policy <= next_k0;
            rsvd_wr                    <= next_rsvd;
            reg_rdata                  <= next_rdata;
        end
    end

    // ***********************************************************
    // boot isa capture
    // ***********************************************************
    always_comb begin
        next_cfg_cnt  = cfg_cnt;
        next_boot_sel = boot_sel;
        if (cfg_cnt != CFG_SETTLE) begin
            next_cfg_cnt = cfg_cnt + 2'h1;
            if (cfg_cnt == (CFG_SETTLE - 2'h1)) begin
                next_boot_sel = boot_s2;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            boot_s1            <= 1'b0;
            boot_s2            <= 1'b0;
            cfg_cnt            <= 2'h0;
            boot_sel           <= 1'b0;
            exception_isa_flag <= 1'b1;
            isa_mode           <= ISA_COMP;
        end else if (ce) begin
            boot_s1            <= boot_instruction_set_select;
            boot_s2            <= boot_s1;
            cfg_cnt            <= next_cfg_cnt;
            boot_sel           <= next_boot_sel;
            exception_isa_flag <= core.exc_flag;
            isa_mode           <= core.isa_field;
        end
    end

    // ***********************************************************
    // cache attributes
    // ***********************************************************
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            icache_cacheable <= 1'b0;
            icache_wback     <= 1'b0;
            icache_walloc    <= 1'b0;
            dcache_cacheable <= 1'b0;
            dcache_wback     <= 1'b0;
            dcache_walloc    <= 1'b0;
            flash_ecc_en     <= ECC_RST;
        end else if (ce) begin
            // both l1 caches follow the attribute, never coherent
            icache_cacheable <= (fixed_segment_cache_policy != K0_UNC) &&
                                !fixed_segment_cache_policy[2];
            icache_wback  <= (fixed_segment_cache_policy == K0_WB_WA);
            icache_walloc <= (fixed_segment_cache_policy == K0_WB_WA) ||
                             (fixed_segment_cache_policy == K0_WT_WA);
            dcache_cacheable <= (fixed_segment_cache_policy != K0_UNC) &&
                                !fixed_segment_cache_policy[2];
            dcache_wback  <= (fixed_segment_cache_policy == K0_WB_WA);
            dcache_walloc <= (fixed_segment_cache_policy == K0_WB_WA) ||
                             (fixed_segment_cache_policy == K0_WT_WA);
            flash_ecc_en  <= ecc_en;
        end
    end

    // ***********************************************************
    // fetch and prefetch control
    // ***********************************************************
    assign accept = fetch_req && (state == ST_IDLE);
    assign pf_hit = pf_valid && (pf_addr == fetch_addr);

    always_comb begin
        unique case (prefetch_mode_select)
            PF_ANY:   pf_allow = 1'b1;
            PF_CPU:   pf_allow = (kind != ACC_OTHER);
            PF_INSTR: pf_allow = (kind == ACC_INSTR);
            PF_OFF:   pf_allow = 1'b0;
        endcase
    end

    always_comb begin
        next_state       = state;
        next_kind        = kind;
        next_pf_valid    = pf_valid && !ctl_wr;
        next_pf_addr     = pf_addr;
        next_pf_data     = pf_data;
        next_fetch_valid = 1'b0;
        next_fetch_rdata = fetch_rdata;
        next_fetch_is32  = fetch_is32;
        next_flash_rd    = flash_rd;
        next_flash_addr  = flash_addr;
        core.start       = 1'b0;
        unique case (state)
            ST_IDLE: begin
                if (accept && pf_hit && !ctl_wr) begin
                    next_fetch_valid = 1'b1;
                    next_fetch_rdata = pf_data;
                    next_fetch_is32  = 1'b1;
                    next_pf_valid    = 1'b0;
                end else if (accept) begin
                    next_state      = ST_DEMAND;
                    next_kind       = fetch_kind;
                    next_flash_rd   = 1'b1;
                    next_flash_addr = fetch_addr;
                    core.start      = 1'b1;
                end
            end
            ST_DEMAND: begin
                if (core.done) begin
                    next_flash_rd    = 1'b0;
                    next_fetch_valid = 1'b1;
                    next_fetch_rdata = flash_rdata;
                    next_fetch_is32  = core.is32;
                    next_state       = ST_IDLE;
                    if (pf_allow) begin
                        next_state      = ST_PREF;
                        next_flash_rd   = 1'b1;
                        next_flash_addr = flash_addr + PF_STEP;
                        core.start      = 1'b1;
                    end
                end
            end
            ST_PREF: begin
                if (core.done) begin
                    next_flash_rd = 1'b0;
                    next_state    = ST_IDLE;
                    next_pf_valid = !ctl_wr;
                    next_pf_addr  = flash_addr;
                    next_pf_data  = flash_rdata;
                end
            end
            default: begin
                next_state    = ST_IDLE;
                next_flash_rd = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state       <= ST_IDLE;
            kind        <= ACC_INSTR;
            pf_valid    <= 1'b0;
            pf_addr     <= '0;
            pf_data     <= '0;
            fetch_ready <= 1'b1;
            fetch_valid <= 1'b0;
            fetch_rdata <= '0;
            fetch_is32  <= 1'b1;
            flash_rd    <= 1'b0;
            flash_addr  <= '0;
        end else if (ce) begin
            state       <= next_state;
            kind        <= next_kind;
            pf_valid    <= next_pf_valid;
            pf_addr     <= next_pf_addr;
            pf_data     <= next_pf_data;
            fetch_ready <= (next_state == ST_IDLE);
            fetch_valid <= next_fetch_valid;
            fetch_rdata <= next_fetch_rdata;
            fetch_is32  <= next_fetch_is32;
            flash_rd    <= next_flash_rd;
            flash_addr  <= next_flash_addr;
        end
    end

endmodule : pcwc_top

// >>> logic/pcwc_pkg.sv
// Purpose: constants and types of the prefetch, cache and wait-state block
// Assumes: one clock domain, 32-bit register port, word-addressed flash
// Notes:   all offsets, fields, resets and encodings live here
package pcwc_pkg;

    // ***********************************************************
    // widths
    // ***********************************************************
    localparam int AW = 24;
    localparam int DW = 32;
    localparam int RAW = 8;

    // ***********************************************************
    // register offsets
    // ***********************************************************
    localparam logic [RAW-1:0] REG_PREFETCH_CONTROL_REG = 8'h00;
    localparam logic [RAW-1:0] REG_CP0_16 = 8'h04;
    localparam logic [RAW-1:0] REG_CFG3   = 8'h08;
    localparam logic [RAW-1:0] REG_STATUS = 8'h0c;

    // ***********************************************************
    // field positions
    // ***********************************************************
    localparam int WS_LSB      = 0;
    localparam int PF_LSB      = 4;
    localparam int ECC_BIT     = 7;
    localparam int K0_LSB      = 0;
    localparam int ISA_LSB     = 14;
    localparam int EXC_ISA_BIT = 16;
    localparam int ST_RSVD_BIT = 0;
    localparam int ST_BUSY_BIT = 1;
    localparam int ST_PFV_BIT  = 2;
    localparam int ST_BOOT_BIT = 3;

    // ***********************************************************
    // encodings and reset values
    // ***********************************************************
    localparam logic [1:0] PF_OFF   = 2'h0;
    localparam logic [1:0] PF_INSTR = 2'h1;
    localparam logic [1:0] PF_CPU   = 2'h2;
    localparam logic [1:0] PF_ANY   = 2'h3;
    localparam logic [2:0] WS_RSVD  = 3'h3;
    localparam logic [2:0] K0_WT_NA = 3'h0;
    localparam logic [2:0] K0_WT_WA = 3'h1;
    localparam logic [2:0] K0_UNC   = 3'h2;
    localparam logic [2:0] K0_WB_WA = 3'h3;
    localparam logic [1:0] ISA_WORD = 2'h2;
    localparam logic [1:0] ISA_COMP = 2'h3;
    localparam logic [1:0] PF_RST   = PF_OFF;
    localparam logic [2:0] WS_RST   = 3'h7;
    localparam logic       ECC_RST  = 1'b1;
    localparam logic [2:0] K0_RST   = K0_UNC;
    localparam logic [1:0] CFG_SETTLE = 2'h3;
    localparam logic [AW-1:0] PF_STEP = 24'h000001;

    // ***********************************************************
    // types
    // ***********************************************************
    typedef enum logic [1:0] {
        ACC_INSTR,
        ACC_DATA,
        ACC_OTHER
    } pcwc_acc_e;

endpackage : pcwc_pkg

// >>> logic/pcwc_core_if.sv
// Purpose: carrier between the controller, wait timer and isa decoder
// Assumes: same clock as the controller
// Notes:   ctrl drives start, ws, boot_sel and hword
`timescale 1ns/10ps
interface pcwc_core_if;
    logic       start;
    logic [2:0] ws;
    logic       done;
    logic       boot_sel;
    logic [15:0] hword;
    logic       exc_flag;
    logic [1:0] isa_field;
    logic       is32;

    modport ctrl  (output start, ws, boot_sel, hword,
                   input done, exc_flag, isa_field, is32);
    modport timer (input start, ws, output done);
    modport isa   (input boot_sel, hword,
                   output exc_flag, isa_field, is32);
endinterface : pcwc_core_if

// >>> logic/pcwc_wait_timer.sv
// Purpose: counts flash wait states of one read
// Assumes: start is a one-cycle pulse, ws stable at start
// Notes:   done is high in the last cycle of the read
`timescale 1ns/10ps
module pcwc_wait_timer (
    input  wire logic   clk,
    input  wire logic   ce,
    input  wire logic   reset,
    pcwc_core_if.timer  bus
);
    logic       busy;
    logic [2:0] cnt;
    logic       next_busy;
    logic [2:0] next_cnt;

    // ***********************************************************
    // counter
    // ***********************************************************
    always_comb begin
        next_busy = busy;
        next_cnt  = cnt;
        if (bus.start) begin
            next_busy = 1'b1;
            next_cnt  = bus.ws;
        end else if (busy) begin
            if (cnt == 3'h0) begin
                next_busy = 1'b0;
            end else begin
                next_cnt = cnt - 3'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy <= 1'b0;
            cnt  <= 3'h0;
        end else if (ce) begin
            busy <= next_busy;
            cnt  <= next_cnt;
        end
    end

    assign bus.done = busy && (cnt == 3'h0);

endmodule : pcwc_wait_timer

// >>> logic/pcwc_isa_decode.sv
// Purpose: boot isa selection and opcode length decode
// Assumes: boot_sel is the settled configuration bit
// Notes:   purely combinational
`timescale 1ns/10ps
module pcwc_isa_decode (
    pcwc_core_if.isa bus
);
    import pcwc_pkg::*;

    // ***********************************************************
    // decode
    // ***********************************************************
    always_comb begin
        if (bus.boot_sel) begin
            bus.exc_flag  = 1'b0;
            bus.isa_field = ISA_WORD;
            bus.is32      = 1'b1;
        end else begin
            bus.exc_flag  = 1'b1;
            bus.isa_field = ISA_COMP;
            // short opcodes use major groups 1 to 3 of bits 12:10
            bus.is32 = !((bus.hword[12:10] == 3'h1) ||
                         (bus.hword[12:10] == 3'h2) ||
                         (bus.hword[12:10] == 3'h3));
        end
    end

endmodule : pcwc_isa_decode

// >>> tb/pcwc_flash_model.sv
// Purpose: program flash array on the far side of pcwc_top
// Assumes: word data depends only on the address while flash_rd is high
// Notes:   inverted data outside reads
`timescale 1ns/10ps
module pcwc_flash_model (
    input  wire logic [pcwc_pkg::AW-1:0] flash_addr,
    input  wire logic                    flash_rd,
    output logic      [pcwc_pkg::DW-1:0] flash_rdata
);
    import pcwc_pkg::*;
    assign flash_rdata = flash_rd ? {8'ha5, flash_addr}
                                  : ~{8'ha5, flash_addr};
endmodule : pcwc_flash_model

// >>> tb/pcwc_chk_properties.sv
// Purpose: port checker for pcwc_top
// Assumes: ce held high
// Notes:   mirrors written fields
`timescale 1ns/10ps
module pcwc_chk (
    input wire logic                     clk,
    input wire logic                     reset,
    input wire logic [pcwc_pkg::RAW-1:0] reg_addr,
    input wire logic [31:0]              reg_wdata,
    input wire logic                     reg_wr,
    input wire logic                     fetch_ready,
    input wire logic                     fetch_valid,
    input wire logic                     flash_rd,
    input wire logic                     flash_ecc_en,
    input wire logic                     icache_cacheable,
    input wire logic                     icache_wback,
    input wire logic                     icache_walloc,
    input wire logic                     dcache_cacheable,
    input wire logic                     dcache_wback,
    input wire logic                     dcache_walloc,
    input wire logic                     exception_isa_flag,
    input wire logic [1:0]               isa_mode
);
    import pcwc_pkg::*;
    logic [2:0] ws_m, next_ws;
    logic [1:0] mode_m, next_mode;
    logic [3:0] run, next_run;
    wire pw = reg_wr && reg_addr == REG_PREFETCH_CONTROL_REG;
    wire aw = reg_wr && reg_addr == REG_CP0_16;
    wire [2:0] ic = {icache_cacheable, icache_wback, icache_walloc};
    wire [2:0] dc = {dcache_cacheable, dcache_wback, dcache_walloc};
    function automatic logic [2:0] k0_dec(input logic [2:0] c);
        return c == 3'h3 ? 3'h7 : c == 3'h1 ? 3'h5 : c == 3'h0 ? 3'h4 : 3'h0;
    endfunction : k0_dec
    always_comb begin
        next_ws = ws_m;
        next_mode = mode_m;
        next_run = flash_rd ? run + 4'h1 : 4'h0;
        if (pw) begin
            next_mode = reg_wdata[5:4];
            if (reg_wdata[2:0] != WS_RSVD)
                next_ws = reg_wdata[2:0];
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ws_m <= WS_RST;
            mode_m <= PF_RST;
            run <= 4'h0;
        end else begin
            ws_m <= next_ws;
            mode_m <= next_mode;
            run <= next_run;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    ws_count_a: assert property (
        $fell(flash_rd) && mode_m == PF_OFF |-> run == ws_m + 4'h1)
        else $error("flash read length wrong");
    ret_end_a: assert property (
        $fell(flash_rd) && mode_m == PF_OFF |-> fetch_valid)
        else $error("no return at read end");
    busy_ready_a: assert property (flash_rd |-> !fetch_ready)
        else $error("ready during flash read");
    isa_pair_a: assert property (
        isa_mode[1] && exception_isa_flag == isa_mode[0])
        else $error("isa flag and field disagree");
    ecc_copy_a: assert property (
        pw |-> ##2 flash_ecc_en == $past(reg_wdata[7], 2))
        else $error("ecc enable not copied");
    icache_attr_a: assert property (
        aw |-> ##2 ic == k0_dec($past(reg_wdata[2:0], 2)))
        else $error("instruction cache attribute wrong");
    dcache_attr_a: assert property (
        aw |-> ##2 dc == k0_dec($past(reg_wdata[2:0], 2)))
        else $error("data cache attribute wrong");
    attr_hold_a: assert property (
        pw |-> ##2 $stable(ic) && $stable(dc))
        else $error("prefetch write moved cache attribute");
    cover property ($fell(flash_rd) && ws_m == 3'h7);
    cover property (pw && reg_wdata[2:0] == WS_RSVD);
    cover property (aw && reg_wdata[2:0] == K0_WB_WA);
endmodule : pcwc_chk
bind pcwc_top pcwc_chk i_pcwc_chk (.*);

// >>> tb/tb_top.sv
// Purpose: self-checking bench for pcwc_top
// Assumes: ce held high, flash model answers at once
// Notes:   register and fetch tasks with expected values
`timescale 1ns/10ps
module tb_top;
    import pcwc_pkg::*;
    logic        clk, ce, reset, reg_wr, reg_rd, boot, fetch_req, flash_rd;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, fetch_rdata, flash_rdata;
    logic [23:0] fetch_addr, flash_addr;
    pcwc_acc_e   fetch_kind;
    logic        fetch_ready, fetch_valid, fetch_is32, flash_ecc_en, exc;
    logic        ic_c, ic_w, ic_a, dc_c, dc_w, dc_a;
    logic [1:0]  isa_mode;
    int          err_total, check_count, lat, fl, pf;
    logic [2:0]  ws_tab [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
    pcwc_top i_pcwc_top (.clk, .ce, .reset, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .boot_instruction_set_select(boot), .fetch_req,
        .fetch_kind, .fetch_addr, .fetch_ready, .fetch_valid, .fetch_rdata,
        .fetch_is32, .flash_rd, .flash_addr, .flash_rdata, .flash_ecc_en,
        .icache_cacheable(ic_c), .icache_wback(ic_w), .icache_walloc(ic_a),
        .dcache_cacheable(dc_c), .dcache_wback(dc_w), .dcache_walloc(dc_a),
        .exception_isa_flag(exc), .isa_mode);
    pcwc_flash_model i_pcwc_flash_model (.flash_addr, .flash_rd, .flash_rdata);
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ****************************************
    // tasks
    // ****************************************
    task results;
        if (err_total == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : results
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task tmo(input int n);
        if (n >= 60) begin
            err_total++;
            results;
        end
    endtask : tmo
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        chk(nm, e, reg_rdata);
    endtask : rd
    task rdy;
        int n;
        n = 0;
        while (!fetch_ready && n < 60) begin
            @(negedge clk);
            fl += flash_rd;
            n++;
        end
        tmo(n);
    endtask : rdy
    task fetch(input logic [23:0] a, input int k);
        rdy;
        @(posedge clk);
        fetch_req <= 1'b1;
        fetch_addr <= a;
        fetch_kind <= pcwc_acc_e'(k);
        @(posedge clk);
        fetch_req <= 1'b0;
        lat = 0;
        fl = 0;
        do begin
            @(negedge clk);
            lat++;
            fl += flash_rd;
        end while (!fetch_valid && lat < 60);
        tmo(lat);
        rdy;
    endtask : fetch
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        {ce, reset, boot} = 3'h7;
        {reg_wr, reg_rd, fetch_req} = 3'h0;
        {reg_addr, reg_wdata, fetch_addr} = '0;
        fetch_kind = ACC_INSTR;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (8) @(posedge clk);
        rd(REG_PREFETCH_CONTROL_REG, 32'h87, "prefetch_control_reg");
        rd(8'h10, 32'h0, "unmapped");
        rd(REG_CFG3, 32'h8000, "cfg3");
        chk("isa", 32'h2, {exc, isa_mode});
        for (int i = 0; i < 4; i++) begin
            wr(REG_CP0_16, 32'(i));
            rd(REG_CP0_16, 32'(i), "attr");
        end
        foreach (ws_tab[i]) begin
            wr(REG_PREFETCH_CONTROL_REG, 32'h80 | 32'(ws_tab[i]));
            fetch(24'h123, 0);
            chk("latency", 32'(ws_tab[i]) + 2, lat);
            chk("flash cycles", 32'(ws_tab[i]) + 1, fl);
            chk("data", {8'ha5, 24'h123}, fetch_rdata);
            chk("is32", 32'h1, fetch_is32);
        end
        wr(REG_PREFETCH_CONTROL_REG, 32'h83);
        rd(REG_PREFETCH_CONTROL_REG, 32'h87, "prefetch_control_reg");
        rd(REG_STATUS, 32'h9, "status");
        wr(REG_STATUS, 32'h1);
        rd(REG_STATUS, 32'h8, "status");
        for (int m = 0; m < 4; m++)
            for (int k = 0; k < 3; k++) begin
                pf = m == 3 || (m == 2 && k < 2) || (m == 1 && k == 0);
                wr(REG_PREFETCH_CONTROL_REG, 32'(m << 4) | 32'h1);
                fetch(24'(16 * m + 4 * k), k);
                chk("flash cycles", pf ? 4 : 2, fl);
                fetch(24'(16 * m + 4 * k + 1), k);
                chk("latency", pf ? 1 : 3, lat);
                chk("data", {8'ha5, fetch_addr}, fetch_rdata);
            end
        fetch(24'h80, 0);
        wr(REG_PREFETCH_CONTROL_REG, 32'h31);
        fetch(24'h81, 0);
        chk("latency", 32'h3, lat);
        @(posedge clk);
        reset <= 1'b1;
        boot <= 1'b0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        repeat (8) @(posedge clk);
        rd(REG_CFG3, 32'h1c000, "cfg3");
        chk("isa", 32'h7, {exc, isa_mode});
        wr(REG_PREFETCH_CONTROL_REG, 32'h80);
        fetch(24'h000400, 0);
        chk("is32", 32'h0, fetch_is32);
        fetch(24'h001c00, 0);
        chk("is32", 32'h1, fetch_is32);
        results;
    end
endmodule : tb_top
